// ---- hdl/tdq_pkg.sv ----
package tdq_pkg;

  // Register byte offsets, decoded on haddr[11:0]
  localparam logic [11:0] OFS_BASE_LO  = 12'h830;
  localparam logic [11:0] OFS_BASE_HI  = 12'h834;
  localparam logic [11:0] OFS_END      = 12'h838;
  localparam logic [11:0] OFS_RD_PTR   = 12'h83c;
  localparam logic [11:0] OFS_WR_PTR   = 12'h840;
  localparam logic [11:0] OFS_FLUSH_TM = 12'h844;
  localparam logic [11:0] OFS_STATUS   = 12'h848;
  localparam logic [11:0] OFS_DMA_CTRL = 12'h84c;
  localparam logic [11:0] OFS_Q_CTRL   = 12'h880;

  // Queue control fields
  localparam int CTL_BURST_BIT = 3;
  localparam int CTL_FLUSH_BIT = 4;
  localparam int CTL_THR_LSB   = 8;
  localparam int CTL_THR_W     = 3;
  localparam logic [15:0] CTL_MASK = 16'h0718;

  // Status and own control fields
  localparam int STAT_WR_BIT   = 0;
  localparam int STAT_ERR_BIT  = 1;
  localparam int DCTL_EN_BIT   = 0;
  localparam int DCTL_WIRQ_BIT = 1;
  localparam int DCTL_EIRQ_BIT = 2;

  // Reset values
  localparam logic [15:0] RST_REG16 = 16'h0000;
  localparam logic [2:0]  RST_CTL3  = 3'h0;

  // Descriptor layout
  localparam int DESC_OFS_LSB = 0;
  localparam int DESC_CH_LSB  = 16;
  localparam int DESC_ST_LSB  = 26;

  // Burst store and flush timer
  localparam int          FIFO_DEPTH = 8;
  localparam logic [3:0]  HIGH_WATER = 4'h6;
  localparam int          TIMER_DIV  = 256;
  localparam logic [15:0] TM_CODE_MAX = 16'hffff;
  localparam logic [16:0] TM_COUNT_MAX = 17'h10000;

  typedef enum logic [1:0] {ST_IDLE, ST_SINGLE, ST_BURST} tdq_state_t;

  // Pointer after one dword, wrapping past the end offset to zero
  function automatic logic [15:0] next_ptr(input logic [15:0] p,
                                           input logic [15:0] e);
    next_ptr = (p >= e) ? 16'h0000 : p + 16'h0001;
  endfunction

  // Timer code to count: codes map straight, all ones gives 65536
  function automatic logic [16:0] timer_load(input logic [15:0] c);
    timer_load = (c == TM_CODE_MAX) ? TM_COUNT_MAX : {1'b0, c};
  endfunction

endpackage

// ---- hdl/tdq_done_fifo.sv ----
`timescale 1ns/1ps
module tdq_done_fifo
  import tdq_pkg::*;
(
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // Fill side
  input  wire logic        push,
  input  wire logic [31:0] wdata,
  // Drain side
  input  wire logic        pop,
  input  wire logic        clear,
  output logic      [31:0] rdata,
  // State
  output logic      [3:0]  count,
  output logic             full,
  output logic             empty
);

  logic [31:0] mem_q [FIFO_DEPTH];
  logic [2:0]  wr_q;
  logic [2:0]  rd_q;
  logic [3:0]  cnt_q;
  logic        do_push;
  logic        do_pop;

  assign full    = (cnt_q == 4'(FIFO_DEPTH));
  assign empty   = (cnt_q == 4'h0);
  assign count   = cnt_q;
  assign rdata   = mem_q[rd_q];
  assign do_push = push && !full && !clear;
  assign do_pop  = pop && !empty && !clear;

  // Storage needs no reset; only the pointers say what is valid
  always_ff @(posedge hclk) begin
    if (do_push) begin
      mem_q[wr_q] <= wdata;
    end
  end

  // Pointers and fill level
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q  <= 3'h0;
      rd_q  <= 3'h0;
      cnt_q <= 4'h0;
    end else if (clear) begin
      wr_q  <= 3'h0;
      rd_q  <= 3'h0;
      cnt_q <= 4'h0;
    end else begin
      if (do_push) wr_q <= wr_q + 3'h1;
      if (do_pop)  rd_q <= rd_q + 3'h1;
      cnt_q <= cnt_q + 4'(do_push) - 4'(do_pop);
    end
  end

endmodule // tdq_done_fifo

// ---- hdl/tdq_flush_timer.sv ----
`timescale 1ns/1ps
module tdq_flush_timer
  import tdq_pkg::*;
(
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // Control
  input  wire logic        enable,
  input  wire logic        reload,
  input  wire logic [15:0] reload_code,
  // Result
  output logic             expired
);

  logic [7:0]  div_q;
  logic [16:0] cnt_q;
  logic        tick;

  // One-cycle enable every 256 clocks
  assign tick    = (div_q == 8'(TIMER_DIV - 1));
  assign expired = enable && (cnt_q == 17'h0);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_q <= 8'h00;
    end else begin
      div_q <= div_q + 8'h01;
    end
  end

  // Held at the reload count while burst mode is off
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_q <= 17'h0;
    end else if (!enable || reload) begin
      cnt_q <= timer_load(reload_code);
    end else if (tick && cnt_q != 17'h0) begin
      cnt_q <= cnt_q - 17'h1;
    end
  end

endmodule // tdq_flush_timer

// ---- hdl/tdq_writer.sv ----
// Operation
// RULE1: Queue is full when read pointer is one slot past write pointer.
// RULE2: Write address is base plus write pointer; pointer steps one dword.
// RULE3: Stepping past the end offset loads the write pointer with zero.
// RULE4: Nothing is posted until the transmit DMA enable bit is set.
// RULE5: Completion writes set the write flag, subject to the threshold.
// RULE6: Threshold code n sets the flag after 2**n writes.
// RULE7: Single write into a full queue sets error, skips, keeps pointer.
// RULE8: An eight-dword store holds descriptors for burst writing.
// RULE9: In burst mode the store drains once six descriptors wait.
// RULE10: A burst writes only as many descriptors as the queue has room.
// RULE11: No room at all: error flag, nothing written, pointer kept.
// RULE12: A burst advances the pointer per word and sets the write flag.
// RULE13: A sixteen-bit flush timer counts down every 256 clocks.
// RULE14: The flush timer only matters while burst mode is on.
// RULE15: Every queue write reloads the flush timer from its register.
// RULE16: Software loads a nonzero timer code before enabling bursts.
// RULE17: Timer code 0001h counts one, FFFFh counts 65536.
// RULE18: Control bit 3 selects burst writing; clear means one at a time.
// RULE19: Control bit 4 drains the store; software clears it again.
// RULE20: Write and error flags each raise an interrupt when enabled.
// RULE21: Queue is empty when read and write pointers are equal.
// RULE22: After setup only the device moves the write pointer.
// RULE23: Descriptor: offset bits 0-15, channel 16-23, status 26-28.
// RULE24: Timer expiry in burst mode drains a non-empty store.
// RULE25: Pointers and end are dword offsets from the joined base.
//
// Local design decision: the AHB-Lite slave port.
`timescale 1ns/1ps
module tdq_writer
  import tdq_pkg::*;
(
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic      [31:0] hrdata,
  // Completion descriptors from the transmit engine
  input  wire logic        desc_valid,
  output logic             desc_ready,
  input  wire logic [15:0] desc_offset,
  input  wire logic [7:0]  desc_channel,
  input  wire logic [2:0]  desc_status,
  // Host memory write port
  output logic             mem_req,
  output logic      [31:0] mem_addr,
  output logic      [31:0] mem_data,
  output logic             mem_last,
  input  wire logic        mem_ack,
  // Interrupt requests
  output logic             write_irq,
  output logic             error_irq
);

  // Registers
  logic [15:0] base_lo_q;
  logic [15:0] base_hi_q;
  logic [15:0] end_q;
  logic [15:0] rp_q;
  logic [15:0] wp_q;
  logic [15:0] tm_code_q;
  logic [15:0] qctl_q;
  logic [2:0]  dctl_q;
  logic        wr_flag_q;
  logic        err_flag_q;
  logic [7:0]  wcnt_q;
  logic [31:0] data_q;
  tdq_state_t  state_q;

  // Bus phase capture
  logic        dph_q;
  logic        dwr_q;
  logic [11:0] da_q;

  // Internal nets
  logic        acc;
  logic        bw;
  logic [15:0] wp_nx;
  logic [15:0] wp_nx2;
  logic        q_full;
  logic        tx_en;
  logic        burst_en;
  logic        flush;
  logic [31:0] desc_word;
  logic        take;
  logic        drain_go;
  logic        wr_ev;
  logic        err_ev;
  logic        fifo_push;
  logic        fifo_pop;
  logic        fifo_clr;
  logic [31:0] fifo_rdata;
  logic [3:0]  fifo_cnt;
  logic        fifo_full;
  logic        fifo_empty;
  logic        tm_expired;
  logic        thr_hit;
  logic [1:0]  st_clr;

  // Writes of 2**code completions per flag
  function automatic logic [8:0] thr_count(input logic [2:0] code);
    thr_count = 9'h001 << code;
  endfunction

  assign tx_en    = dctl_q[DCTL_EN_BIT];
  assign burst_en = qctl_q[CTL_BURST_BIT];
  assign flush    = qctl_q[CTL_FLUSH_BIT];

  // Queue geometry
  assign wp_nx  = next_ptr(wp_q, end_q);        // RULE3
  assign wp_nx2 = next_ptr(wp_nx, end_q);
  assign q_full = (wp_nx == rp_q);              // RULE1 RULE21

  // Write address from joined base and dword offset
  assign mem_addr = {base_hi_q, base_lo_q}
                  + {14'h0000, wp_q, 2'b00};    // RULE2 RULE25

  // Pack one completion word
  always_comb begin
    desc_word = 32'h0000_0000;
    desc_word[DESC_OFS_LSB +: 16] = desc_offset;  // RULE23
    desc_word[DESC_CH_LSB  +: 8]  = desc_channel;
    desc_word[DESC_ST_LSB  +: 3]  = desc_status;
  end

  // Intake: bursts fill the store, single mode waits for an idle port
  assign desc_ready = tx_en && (burst_en ? !fifo_full             // RULE4
                    : (state_q == ST_IDLE && fifo_empty));      // RULE18
  assign take       = desc_valid && desc_ready && !burst_en;
  assign fifo_push  = desc_valid && desc_ready && burst_en;

  // A store left over after leaving burst mode still drains
  assign drain_go = tx_en && !fifo_empty && (state_q == ST_IDLE)
                  && (fifo_cnt >= HIGH_WATER                      // RULE9
                      || tm_expired                              // RULE24
                      || flush                                   // RULE19
                      || !burst_en);

  assign mem_req  = (state_q != ST_IDLE);
  assign mem_data = (state_q == ST_BURST) ? fifo_rdata : data_q;
  // Last word when the store or the queue room runs out
  assign mem_last = (state_q == ST_SINGLE) || fifo_cnt == 4'h1
                  || wp_nx2 == rp_q;
  assign wr_ev    = mem_req && mem_ack;
  assign fifo_pop = wr_ev && (state_q == ST_BURST);

  // No room: error, and the waiting completions are lost
  assign err_ev   = (take && q_full)                            // RULE7
                  || (drain_go && q_full);                      // RULE11
  assign fifo_clr = drain_go && q_full;

  // Write sequencer
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= ST_IDLE;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (take && !q_full) begin
            state_q <= ST_SINGLE;
          end else if (drain_go && !q_full) begin
            state_q <= ST_BURST;
          end
        end
        ST_SINGLE: begin
          if (mem_ack) state_q <= ST_IDLE;
        end
        ST_BURST: begin
          if (mem_ack && mem_last) state_q <= ST_IDLE;      // RULE10
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // Single-mode word holding
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      data_q <= 32'h0000_0000;
    end else if (take) begin
      data_q <= desc_word;
    end
  end

  // Write pointer; the device step wins over a late software write
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wp_q <= RST_REG16;
    end else if (wr_ev) begin
      wp_q <= wp_nx;                              // RULE2 RULE12 RULE22
    end else if (bw && da_q == OFS_WR_PTR) begin
      wp_q <= hwdata[15:0];
    end
  end

  // Threshold counter for the write flag
  assign thr_hit = ({1'b0, wcnt_q} + 9'h001)
                   >= thr_count(qctl_q[CTL_THR_LSB +: CTL_THR_W]); // RULE6

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wcnt_q <= 8'h00;
    end else if (wr_ev) begin
      wcnt_q <= thr_hit ? 8'h00 : wcnt_q + 8'h01;
    end
  end

  // Sticky flags, write-one-to-clear; a set in the same cycle wins
  assign st_clr = (bw && da_q == OFS_STATUS) ? hwdata[1:0] : 2'b00;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_flag_q  <= 1'b0;
      err_flag_q <= 1'b0;
    end else begin
      wr_flag_q  <= (wr_flag_q && !st_clr[STAT_WR_BIT])
                  || (wr_ev && thr_hit);                // RULE5 RULE12
      err_flag_q <= (err_flag_q && !st_clr[STAT_ERR_BIT]) || err_ev;
    end
  end

  assign write_irq = wr_flag_q && dctl_q[DCTL_WIRQ_BIT];  // RULE20
  assign error_irq = err_flag_q && dctl_q[DCTL_EIRQ_BIT]; // RULE20

  // Burst store
  tdq_done_fifo u_fifo (                                  // RULE8
    .hclk    (hclk),
    .hresetn (hresetn),
    .push    (fifo_push),
    .wdata   (desc_word),
    .pop     (fifo_pop),
    .clear   (fifo_clr),
    .rdata   (fifo_rdata),
    .count   (fifo_cnt),
    .full    (fifo_full),
    .empty   (fifo_empty)
  );

  // Flush timer, watched only in burst mode
  tdq_flush_timer u_timer (                               // RULE13
    .hclk        (hclk),
    .hresetn     (hresetn),
    .enable      (burst_en),                              // RULE14
    .reload      (wr_ev),                                 // RULE15
    .reload_code (tm_code_q),                             // RULE17
    .expired     (tm_expired)
  );

  // AHB-Lite: zero wait states, always OKAY
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign acc       = hsel && hready && htrans[1];
  assign bw        = dph_q && dwr_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dph_q <= 1'b0;
      dwr_q <= 1'b0;
      da_q  <= 12'h000;
    end else if (hready) begin
      dph_q <= acc;
      dwr_q <= hwrite;
      da_q  <= haddr[11:0];
    end
  end

  // Software register writes in the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      base_lo_q <= RST_REG16;
      base_hi_q <= RST_REG16;
      end_q     <= RST_REG16;
      rp_q      <= RST_REG16;
      tm_code_q <= RST_REG16;                             // RULE16
      qctl_q    <= RST_REG16;
      dctl_q    <= RST_CTL3;
    end else if (bw) begin
      case (da_q)
        OFS_BASE_LO:  base_lo_q <= hwdata[15:0];
        OFS_BASE_HI:  base_hi_q <= hwdata[15:0];
        OFS_END:      end_q     <= hwdata[15:0];
        OFS_RD_PTR:   rp_q      <= hwdata[15:0];          // RULE22
        OFS_FLUSH_TM: tm_code_q <= hwdata[15:0];
        OFS_Q_CTRL:   qctl_q    <= hwdata[15:0] & CTL_MASK;
        OFS_DMA_CTRL: dctl_q    <= hwdata[2:0];
        default: ;
      endcase
    end
  end

  // Read data from the captured address; unmapped reads return zero
  always_comb begin
    hrdata = 32'h0000_0000;
    if (dph_q && !dwr_q) begin
      case (da_q)
        OFS_BASE_LO:  hrdata[15:0] = base_lo_q;
        OFS_BASE_HI:  hrdata[15:0] = base_hi_q;
        OFS_END:      hrdata[15:0] = end_q;
        OFS_RD_PTR:   hrdata[15:0] = rp_q;
        OFS_WR_PTR:   hrdata[15:0] = wp_q;
        OFS_FLUSH_TM: hrdata[15:0] = tm_code_q;
        OFS_Q_CTRL:   hrdata[15:0] = qctl_q;
        OFS_DMA_CTRL: hrdata[2:0]  = dctl_q;
        OFS_STATUS:   hrdata[1:0]  = {err_flag_q, wr_flag_q};
        default:      hrdata = 32'h0000_0000;
      endcase
    end
  end

  // Checks

  a_wrap_zero: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_ev && wp_q >= end_q |=> wp_q == 16'h0000)  // RULE3
    else $error("write pointer did not wrap to zero");

  a_ptr_step: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_ev && wp_q < end_q |=> wp_q == $past(wp_q) + 16'h0001)  // RULE2
    else $error("write pointer did not step by one");

  a_addr_form: assert property (@(posedge hclk) disable iff (!hresetn)
    mem_req |-> mem_addr[1:0] == 2'b00
      && mem_addr - {base_hi_q, base_lo_q} == {14'h0000, wp_q, 2'b00})  // RULE25
    else $error("write address not base plus pointer");

  a_no_overrun: assert property (@(posedge hclk) disable iff (!hresetn)
    mem_req |-> next_ptr(wp_q, end_q) != rp_q)  // RULE1
    else $error("write issued into a full queue");

  a_err_hold: assert property (@(posedge hclk) disable iff (!hresetn)
    err_ev |=> !mem_req && wp_q == $past(wp_q) && err_flag_q)  // RULE7
    else $error("error case wrote or moved the pointer");

  a_enable_gate: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(mem_req) |-> $past(tx_en))  // RULE4
    else $error("write started with the DMA disabled");

  a_burst_cause: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(mem_req) && state_q == ST_BURST
      |-> $past(fifo_cnt >= HIGH_WATER || tm_expired || flush
                || !burst_en))  // RULE9
    else $error("burst started without a cause");

  a_flag_each: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_ev && qctl_q[CTL_THR_LSB +: CTL_THR_W] == 3'h0
      |=> wr_flag_q)  // RULE5
    else $error("write flag not set after a write");

  a_timer_reload: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_ev && burst_en && tm_code_q > 16'h0001
      |=> !tm_expired [*2])  // RULE15
    else $error("flush timer not reloaded on a write");

  a_single_word: assert property (@(posedge hclk) disable iff (!hresetn)
    take && !q_full |=> mem_req && mem_last
      && mem_data[DESC_OFS_LSB +: 16] == $past(desc_offset))  // RULE18
    else $error("single write not issued as one word");

endmodule // tdq_writer

// ---- testbench/tdq_host_mem.sv ----
`timescale 1ns/1ps
// Host memory: takes queue words after a stall set by the bench
module tdq_host_mem (
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // Write port from the device
  input  wire logic        mem_req,
  input  wire logic [31:0] mem_addr,
  input  wire logic [31:0] mem_data,
  input  wire logic        mem_last,
  output logic             mem_ack,
  // Bench control
  input  wire logic [3:0]  stall
);
  logic [3:0]  wait_q;
  logic [31:0] got_addr[$];
  logic [31:0] got_data[$];
  logic        got_last[$];

  // One-cycle ack, so every word of a burst sees its own stall
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mem_ack <= 1'b0;
      wait_q  <= 4'h0;
    end else if (mem_req && !mem_ack && wait_q >= stall) begin
      mem_ack <= 1'b1;
      wait_q  <= 4'h0;
    end else begin
      mem_ack <= 1'b0;
      wait_q  <= (mem_req && !mem_ack) ? wait_q + 4'h1 : 4'h0;
    end
  end

  // Words land in memory at the acknowledging edge
  always @(posedge hclk) begin
    if (hresetn && mem_req && mem_ack) begin
      got_addr.push_back(mem_addr);
      got_data.push_back(mem_data);
      got_last.push_back(mem_last);
    end
  end
endmodule // tdq_host_mem

// ---- testbench/tb.sv ----
`timescale 1ns/1ps
module tb
  import tdq_pkg::*;
;
  localparam logic [31:0] BASE = 32'h8000_1000;
  logic        hclk, hresetn, hsel, hwrite, desc_valid;
  logic [31:0] haddr, hwdata, rd;
  logic [1:0]  htrans;
  logic [2:0]  hsize, desc_status;
  logic [15:0] desc_offset, wp, endp;
  logic [7:0]  desc_channel;
  logic [3:0]  stall;
  wire logic   hready, hresp, desc_ready, mem_req, mem_last, mem_ack;
  wire logic   write_irq, error_irq;
  wire logic [31:0] hrdata, mem_addr, mem_data;
  int          n_mismatch, checks_done, nw, n;
  logic [31:0] pend[$];
  logic [11:0] offs[10] = '{OFS_BASE_LO, OFS_BASE_HI, OFS_END, OFS_RD_PTR,
    OFS_WR_PTR, OFS_FLUSH_TM, OFS_STATUS, OFS_DMA_CTRL, OFS_Q_CTRL, 12'h900};

  tdq_writer u_tdq_writer (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hreadyout(hready), .hresp(hresp),
    .hrdata(hrdata), .desc_valid(desc_valid), .desc_ready(desc_ready),
    .desc_offset(desc_offset), .desc_channel(desc_channel),
    .desc_status(desc_status), .mem_req(mem_req), .mem_addr(mem_addr),
    .mem_data(mem_data), .mem_last(mem_last), .mem_ack(mem_ack),
    .write_irq(write_irq), .error_irq(error_irq));

  tdq_host_mem u_tdq_host_mem (.hclk(hclk), .hresetn(hresetn),
    .mem_req(mem_req), .mem_addr(mem_addr), .mem_data(mem_data),
    .mem_last(mem_last), .mem_ack(mem_ack), .stall(stall));

  // Clock, 4 ns period
  initial begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end

  task automatic conclude;
    $display("mismatches %0d, checks %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string what);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // One AHB single: hold each phase until hready is seen at an edge
  task automatic ahb(input logic w, input logic [11:0] a,
                     input logic [31:0] wd);
    logic ok;
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= {20'h0, a};
    hwrite <= w;
    // Only the watchdog ends a wait for hready
    do begin
      @(negedge hclk);
      ok = hready;
      @(posedge hclk);
    end while (ok !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do begin
      @(negedge hclk);
      ok = hready;
      rd = hrdata;
      @(posedge hclk);
    end while (ok !== 1'b1);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    ahb(1'b1, a, d);
  endtask

  task automatic rdc(input logic [11:0] a, input logic [31:0] e);
    ahb(1'b0, a, 32'h0);
    chk(rd, e, "register read");
    chk(32'(hresp), 32'h0, "okay response");
  endtask

  // Offer one completion and hold it until taken or 300 cycles pass
  task automatic post(input logic [15:0] o);
    int t;
    @(posedge hclk);
    desc_valid   <= 1'b1;
    desc_offset  <= o;
    desc_channel <= o[7:0] ^ 8'h5a;
    desc_status  <= o[2:0];
    pend.push_back({3'h0, o[2:0], 2'h0, o[7:0] ^ 8'h5a, o});
    t = 0;
    @(negedge hclk);
    while (desc_ready !== 1'b1 && t < 300) begin
      @(negedge hclk);
      t++;
    end
    chk(32'(desc_ready), 32'h1, "completion taken");
    @(posedge hclk);
    desc_valid <= 1'b0;
  endtask

  // Expect n new queue words, in order, from the write pointer on
  task automatic words(input int cnt, input logic burst);
    int t;
    t = 0;
    while (u_tdq_host_mem.got_addr.size() < nw + cnt && t < 3000) begin
      @(negedge hclk);
      t++;
    end
    for (int i = 0; i < cnt; i++) begin
      chk(u_tdq_host_mem.got_addr[nw], BASE + {14'h0, wp, 2'b00}, "addr");
      chk(u_tdq_host_mem.got_data[nw], pend.pop_front(), "word");
      chk(32'(u_tdq_host_mem.got_last[nw]), 32'(!burst || i == cnt - 1),
          "last");
      wp = (wp >= endp) ? 16'h0 : wp + 16'h1;
      nw++;
    end
    chk(32'(u_tdq_host_mem.got_addr.size()), 32'(nw), "word count");
  endtask

  task automatic quiet(input int c);
    repeat (c) @(negedge hclk);
    chk(32'(u_tdq_host_mem.got_addr.size()), 32'(nw), "stray write");
  endtask

  // Watchdog, far beyond the roughly 3k cycles the run needs
  initial begin
    #200000;
    n_mismatch++;
    conclude;
  end

  initial begin
    {hresetn, hsel, hwrite, desc_valid} = 4'h0;
    {haddr, hwdata, htrans, hsize} = {64'h0, 2'b00, 3'b010};
    {desc_offset, desc_channel, desc_status} = 27'h0;
    {stall, nw, wp, endp, n_mismatch, checks_done} = {4'h1, 32'h0, 16'h0,
                                                      16'h3, 64'h0};
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    // Reset values, then an unmapped offset reads zero
    for (int i = 0; i < 10; i++) rdc(offs[i], 32'h0);
    wr(OFS_BASE_LO, 32'h1000);
    wr(OFS_BASE_HI, 32'h8000);
    wr(OFS_END, 32'h3);
    wr(OFS_Q_CTRL, 32'hffff);
    rdc(OFS_Q_CTRL, 32'h0718);
    wr(OFS_Q_CTRL, 32'h0);
    rdc(OFS_BASE_HI, 32'h8000);
    // Transmit disabled: an offered completion stays waiting
    @(posedge hclk);
    desc_valid <= 1'b1;
    n = 0;
    repeat (20) begin
      @(negedge hclk);
      if (desc_ready !== 1'b0) n++;
    end
    chk(32'(n), 32'h0, "taken while disabled");
    @(posedge hclk);
    desc_valid <= 1'b0;
    wr(OFS_DMA_CTRL, 32'h7);
    // Single writes fill the four-slot queue; the fourth would overflow
    for (int i = 0; i < 3; i++) begin
      post(16'(i * 273));
      words(1, 1'b0);
    end
    rdc(OFS_STATUS, 32'h1);
    chk(32'(write_irq), 32'h1, "write irq");
    post(16'h0abc);
    void'(pend.pop_back());
    quiet(40);
    rdc(OFS_STATUS, 32'h3);
    chk(32'(error_irq), 32'h1, "error irq");
    rdc(OFS_WR_PTR, 32'h3);
    wr(OFS_STATUS, 32'h3);
    rdc(OFS_STATUS, 32'h0);
    wr(OFS_RD_PTR, 32'h2);
    post(16'h0bcd);
    words(1, 1'b0);
    rdc(OFS_WR_PTR, 32'h0);
    // Every threshold code; flag only on the last write of each run
    wr(OFS_FLUSH_TM, 32'h2);
    wr(OFS_END, 32'hffff);
    endp = 16'hffff;
    wr(OFS_RD_PTR, 32'h0);
    for (int c = 0; c < 8; c++) begin
      wr(OFS_Q_CTRL, 32'(c) << 8);
      wr(OFS_STATUS, 32'h3);
      for (int k = 1; k <= (1 << c); k++) begin
        post(16'(k));
        words(1, 1'b0);
        rdc(OFS_STATUS, 32'(k == (1 << c)));
      end
    end
    // Burst mode: hold until six, with a slow host
    stall <= 4'h3;
    post(16'h0100);
    words(1, 1'b0);
    wr(OFS_Q_CTRL, 32'h0008);
    for (int i = 0; i < 5; i++) post(16'(16'h0200 + i));
    quiet(100);
    post(16'h0205);
    words(6, 1'b1);
    // Flush timer of two ticks drains a small remainder
    post(16'h0300);
    post(16'h0301);
    quiet(150);
    words(2, 1'b1);
    // Forced drain
    for (int i = 0; i < 3; i++) post(16'(16'h0400 + i));
    wr(OFS_Q_CTRL, 32'h0018);
    words(3, 1'b1);
    wr(OFS_Q_CTRL, 32'h0008);
    // Room for four only; the rest waits for the next drain
    wr(OFS_RD_PTR, 32'(wp + 16'h5));
    for (int i = 0; i < 6; i++) post(16'(16'h0500 + i));
    words(4, 1'b1);
    quiet(30);
    wr(OFS_RD_PTR, 32'(wp + 16'h100));
    wr(OFS_Q_CTRL, 32'h0018);
    words(2, 1'b1);
    wr(OFS_Q_CTRL, 32'h0008);
    // No room at all: error, nothing written, pointer kept
    wr(OFS_STATUS, 32'h3);
    wr(OFS_RD_PTR, 32'(wp + 16'h1));
    for (int i = 0; i < 6; i++) post(16'(16'h0600 + i));
    repeat (6) void'(pend.pop_back());
    quiet(60);
    rdc(OFS_STATUS, 32'h2);
    rdc(OFS_WR_PTR, 32'(wp));
    conclude;
  end
endmodule // tb
